/* File: rtl/addr_decode_map.vh */
// Purpose: constants shared by the addressing-mode decoder files
// Assumes: byte-wide instruction stream, 16-bit address space
// Notes:   definitions only
`ifndef ADDR_DECODE_MAP_VH
`define ADDR_DECODE_MAP_VH

// prebyte values and the relative call opcode as they appear in the instruction stream
`define SECOND_INDEX_PREBYTE          8'h90
`define INDIRECT_PREBYTE              8'h92
`define SECOND_INDEX_INDIRECT_PREBYTE 8'h91
`define RELATIVE_CALL_OP              8'had

// held prebyte codes
`define PRE_NONE      2'h0
`define PRE_SECOND    2'h1
`define PRE_INDIRECT  2'h2
`define PRE_SECOND_IND 2'h3

// addressing modes reported on modeOut
`define MODE_INH      5'h00
`define MODE_IMM      5'h01
`define MODE_DIR_S    5'h02
`define MODE_DIR_L    5'h03
`define MODE_IDX_0    5'h04
`define MODE_IDX_S    5'h05
`define MODE_IDX_L    5'h06
`define MODE_IND_S    5'h07
`define MODE_IND_L    5'h08
`define MODE_INDX_S   5'h09
`define MODE_INDX_L   5'h0a
`define MODE_REL_D    5'h0b
`define MODE_REL_I    5'h0c
`define MODE_BIT_D    5'h0d
`define MODE_BIT_I    5'h0e
`define MODE_BITREL_D 5'h0f
`define MODE_BITREL_I 5'h10
`define MODE_ILLEGAL  5'h1f

// opcode high-nibble groups
`define GRP_BIT_REL   4'h0
`define GRP_BIT       4'h1
`define GRP_REL       4'h2
`define GRP_RMW_DIR   4'h3
`define GRP_INH_A     4'h4
`define GRP_INH_X     4'h5
`define GRP_RMW_IDXS  4'h6
`define GRP_RMW_IDX0  4'h7
`define GRP_INH_M1    4'h8
`define GRP_INH_M2    4'h9
`define GRP_IMM       4'ha
`define GRP_DIR_S     4'hb
`define GRP_DIR_L     4'hc
`define GRP_IDX_L     4'hd
`define GRP_IDX_S     4'he
`define GRP_IDX_0     4'hf

// low nibbles of jump and call within a group
`define LO_JUMP       4'hc
`define LO_CALL       4'hd

`endif

/* File: rtl/ptr_fetch.v */
// Purpose: reads a one- or two-byte pointer starting in page zero
// Assumes: memory answers with memRdValid while memRdReq is high
// Notes:   word pointers are stored high byte first
`timescale 1ns/100ps
module ptr_fetch (
  input  wire        clk,
  input  wire        rst,
  input  wire        start,
  input  wire [7:0]  base,
  input  wire [1:0]  count,
  input  wire        memRdValid,
  input  wire [7:0]  memRdData,
  output wire        memRdReq,
  output wire [15:0] memAddr,
  output reg  [15:0] ptrVal_r,
  output reg         done_r
);
  reg        busy_r;
  reg [1:0]  cnt_r;
  reg [1:0]  need_r;
  reg [15:0] addr_r;

  assign memRdReq = busy_r;
  assign memAddr  = addr_r;

  // shift bytes in high first so a one-byte pointer lands zero-extended
  always @(posedge clk) begin
    if (rst) begin
      busy_r   <= 1'b0;
      cnt_r    <= 2'h0;
      need_r   <= 2'h0;
      addr_r   <= 16'h0000;
      ptrVal_r <= 16'h0000;
      done_r   <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        busy_r   <= 1'b1;
        cnt_r    <= 2'h0;
        need_r   <= count;
        addr_r   <= {8'h00, base};
        ptrVal_r <= 16'h0000;
      end else if (busy_r && memRdValid) begin
        ptrVal_r <= {ptrVal_r[7:0], memRdData};
        cnt_r    <= cnt_r + 2'h1;
        addr_r   <= addr_r + 16'h0001; // may leave page zero, on purpose
        if (cnt_r + 2'h1 == need_r) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end
endmodule // ptr_fetch

/* File: rtl/ea_former.v */
// Purpose: forms effective address and relative target from fields
// Assumes: fields are stable while the decoder is in its final state
// Notes:   purely combinational, results are registered by the caller
`timescale 1ns/100ps
`include "addr_decode_map.vh"
module ea_former (
  input  wire [4:0]  mode,
  input  wire [7:0]  idx,
  input  wire [7:0]  ext0,
  input  wire [7:0]  ext1,
  input  wire [15:0] ptr,
  input  wire [15:0] nextPc,
  output reg  [15:0] ea,
  output reg  [15:0] target
);
  // unsigned index add; short forms stay below 16'h01ff by construction
  function [15:0] idxSum;
    input [15:0] b;
    input [7:0]  i;
    begin
      idxSum = b + {8'h00, i};
    end
  endfunction

  // signed 8-bit offset added to the already advanced pc
  function [15:0] relSum;
    input [15:0] pc;
    input [7:0]  off;
    begin
      relSum = pc + {{8{off[7]}}, off};
    end
  endfunction

  always @* begin
    ea     = 16'h0000;
    target = 16'h0000;
    case (mode)
      `MODE_IMM, `MODE_INH: ea = 16'h0000;
      `MODE_DIR_S, `MODE_BIT_D: ea = {8'h00, ext0};
      `MODE_DIR_L:  ea = {ext0, ext1};
      `MODE_IDX_0:  ea = {8'h00, idx};
      `MODE_IDX_S:  ea = idxSum({8'h00, ext0}, idx);
      `MODE_IDX_L:  ea = idxSum({ext0, ext1}, idx);
      `MODE_IND_S, `MODE_BIT_I: ea = {8'h00, ptr[7:0]};
      `MODE_IND_L:  ea = ptr;
      `MODE_INDX_S: ea = idxSum({8'h00, ptr[7:0]}, idx);
      `MODE_INDX_L: ea = idxSum(ptr, idx);
      `MODE_REL_D:  target = relSum(nextPc, ext0);
      `MODE_REL_I:  target = relSum(nextPc, ptr[7:0]);
      `MODE_BITREL_D: begin
        ea     = {8'h00, ext0};
        target = relSum(nextPc, ext1);
      end
      `MODE_BITREL_I: begin
        ea     = {8'h00, ptr[7:0]};
        target = relSum(nextPc, ext1);
      end
      default: begin
        ea     = 16'h0000;
        target = 16'h0000;
      end
    endcase
  end
endmodule // ea_former

/* File: rtl/addr_mode_decoder.v */
// Purpose: instruction length and effective-address decoder
// Assumes: one instruction byte offered per handshake on instrByte
// Notes:   pointer reads go through ptr_fetch, address math in ea_former
//
// Overview of operation
// - inherent instructions are one opcode byte with no operand bytes
// - immediate instructions carry one operand value byte after the opcode
// - short direct uses the following byte as a page-zero address
// - long direct uses the following two bytes as a 16-bit address
// - indexed address is index register plus instruction offset, unsigned
// - no-offset indexed uses the index register alone, no extra byte
// - short indexed adds a one-byte offset, reaching up to 1FE
// - long indexed adds a two-byte offset, reaching the full space
// - indirect reads a pointer at the following byte, then uses it
// - short indirect reads a one-byte pointer, operand in page zero
// - long indirect reads a two-byte pointer via one address byte
// - indirect indexed adds index register to the pointer read
// - short indirect indexed adds index to a byte pointer, up to 1FE
// - long indirect indexed adds index to a word pointer
// - memory read-modify-write, call and jump have only short forms
// - relative modes add a signed 8-bit offset to the pc
// - relative direct offset is the byte after the opcode
// - relative indirect offset is read from memory at following byte
// - instructions are one to four bytes: prebyte, opcode, 0-2 bytes
// - three prebytes are recognised ahead of the opcode
// - second-index prebyte swaps first index for second index
// - indirect prebyte turns direct, short indexed or long indexed forms indirect
// - second-index indirect prebyte uses second index when indirect
// - relative offset applies to pc already past the instruction
`timescale 1ns/100ps
`include "addr_decode_map.vh"
module addr_mode_decoder (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  instrByte,
  input  wire        instrValid,
  input  wire [15:0] instrPc,
  output wire        instrReady,
  input  wire [7:0]  xIndex,
  input  wire [7:0]  yIndex,
  output wire        memRdReq,
  output wire [15:0] memAddr,
  input  wire        memRdValid,
  input  wire [7:0]  memRdData,
  output reg         decodeDone_r,
  output reg  [4:0]  modeOut_r,
  output reg  [7:0]  opcodeOut_r,
  output reg  [2:0]  instrLen_r,
  output reg  [15:0] eaAddr_r,
  output reg  [7:0]  immOperand_r,
  output reg  [15:0] targetPc_r,
  output reg  [15:0] nextPc_r,
  output reg         hasTarget_r,
  output reg         useSecondIndex_r,
  output reg         illegalOp_r
);
  // one-hot states
  localparam [3:0] S_OPC  = 4'h1;
  localparam [3:0] S_EXT  = 4'h2;
  localparam [3:0] S_PTR  = 4'h4;
  localparam [3:0] S_DONE = 4'h8;

  reg [3:0]  state_r;
  reg [1:0]  pre_r;
  reg [7:0]  opc_r;
  reg [4:0]  mode_r;
  reg [1:0]  extNeed_r;
  reg [1:0]  extCnt_r;
  reg [1:0]  ptrNeed_r;
  reg        useY_r;
  reg        bad_r;
  reg [7:0]  ext0_r;
  reg [7:0]  ext1_r;
  reg [2:0]  len_r;
  reg [15:0] pcBase_r;

  // classifier outputs for the byte on instrByte
  reg [4:0]  cMode;
  reg [1:0]  cExt;
  reg [1:0]  cPtr;
  reg        cY;
  reg        cBad;
  reg        isPre;
  reg [1:0]  preCode;

  wire [3:0]  hi = instrByte[7:4];
  wire [3:0]  lo = instrByte[3:0];
  wire        noPre   = (pre_r == `PRE_NONE);
  wire        preSec  = (pre_r == `PRE_SECOND);
  wire        preInd  = (pre_r == `PRE_INDIRECT);
  wire        preSecI = (pre_r == `PRE_SECOND_IND);
  wire        lastExt;
  wire        ptrStart;
  wire [7:0]  ptrBase;
  wire [15:0] ptrVal;
  wire        ptrDone;
  wire [15:0] eaNow;
  wire [15:0] targetNow;
  wire [15:0] nextPc;

  // a prebyte is only taken as such when none is held yet
  always @* begin
    isPre   = 1'b0;
    preCode = `PRE_NONE;
    if (noPre) begin
      if (instrByte == `SECOND_INDEX_PREBYTE) begin
        isPre   = 1'b1;
        preCode = `PRE_SECOND;
      end else if (instrByte == `INDIRECT_PREBYTE) begin
        isPre   = 1'b1;
        preCode = `PRE_INDIRECT;
      end else if (instrByte == `SECOND_INDEX_INDIRECT_PREBYTE) begin
        isPre   = 1'b1;
        preCode = `PRE_SECOND_IND;
      end
    end
  end

  // opcode group decode; anything not listed under a prebyte is illegal
  always @* begin
    cMode = `MODE_INH;
    cExt  = 2'h0;
    cPtr  = 2'h0;
    cY    = preSec | preSecI;
    cBad  = 1'b0;
    case (hi)
      `GRP_BIT_REL: begin
        cExt  = 2'h2;
        cMode = preInd ? `MODE_BITREL_I : `MODE_BITREL_D;
        cPtr  = preInd ? 2'h1 : 2'h0;
        cBad  = preSec | preSecI;
      end
      `GRP_BIT: begin
        cExt  = 2'h1;
        cMode = preInd ? `MODE_BIT_I : `MODE_BIT_D;
        cPtr  = preInd ? 2'h1 : 2'h0;
        cBad  = preSec | preSecI;
      end
      `GRP_REL: begin
        cExt  = 2'h1;
        cMode = preInd ? `MODE_REL_I : `MODE_REL_D;
        cPtr  = preInd ? 2'h1 : 2'h0;
        cBad  = preSec | preSecI;
      end
      `GRP_RMW_DIR: begin
        cExt  = 2'h1; // only short direct exists here
        cMode = preInd ? `MODE_IND_S : `MODE_DIR_S;
        cPtr  = preInd ? 2'h1 : 2'h0;
        cBad  = preSec | preSecI;
      end
      `GRP_INH_A, `GRP_INH_X, `GRP_INH_M1, `GRP_INH_M2: begin
        cExt  = 2'h0; // opcode alone
        cMode = `MODE_INH;
        cBad  = preInd | preSecI | (!noPre && hi == `GRP_INH_M2 &&
                lo <= 4'h2); // stacked prebyte
      end
      `GRP_RMW_IDXS, `GRP_IDX_S: begin
        cExt  = 2'h1;
        cMode = (preInd | preSecI) ? `MODE_INDX_S : `MODE_IDX_S;
        cPtr  = (preInd | preSecI) ? 2'h1 : 2'h0;
      end
      `GRP_RMW_IDX0, `GRP_IDX_0: begin
        cExt  = 2'h0;
        cMode = `MODE_IDX_0;
        cBad  = preInd | preSecI;
      end
      `GRP_IMM: begin
        cExt = 2'h1;
        if (instrByte == `RELATIVE_CALL_OP) begin
          cMode = preInd ? `MODE_REL_I : `MODE_REL_D;
          cPtr  = preInd ? 2'h1 : 2'h0;
          cBad  = preSec | preSecI;
        end else begin
          cMode = `MODE_IMM;
          cBad  = preInd | preSecI;
        end
      end
      `GRP_DIR_S: begin
        cExt  = 2'h1;
        cMode = preInd ? `MODE_IND_S : `MODE_DIR_S;
        cPtr  = preInd ? 2'h1 : 2'h0;
        cBad  = preSecI;
      end
      `GRP_DIR_L: begin
        cExt  = preInd ? 2'h1 : 2'h2;
        cMode = preInd ? `MODE_IND_L : `MODE_DIR_L;
        cPtr  = preInd ? 2'h2 : 2'h0;
        cBad  = preSecI | lo == `LO_JUMP | lo == `LO_CALL;
      end
      `GRP_IDX_L: begin
        cExt  = (preInd | preSecI) ? 2'h1 : 2'h2;
        cMode = (preInd | preSecI) ? `MODE_INDX_L : `MODE_IDX_L;
        cPtr  = (preInd | preSecI) ? 2'h2 : 2'h0;
        cBad  = lo == `LO_JUMP | lo == `LO_CALL;
      end
      default: cBad = 1'b1;
    endcase
    if (cBad)
      cMode = `MODE_ILLEGAL;
  end

  // first operand byte is always the pointer address when one is read
  assign lastExt    = (extCnt_r + 2'h1 == extNeed_r);
  assign ptrBase    = (extCnt_r == 2'h0) ? instrByte : ext0_r;
  assign ptrStart   = (state_r == S_EXT) && instrValid && lastExt &&
                      (ptrNeed_r != 2'h0);
  assign instrReady = (state_r == S_OPC) || (state_r == S_EXT);
  assign nextPc     = pcBase_r + {13'h0000, len_r};

  ptr_fetch u_ptr (
    .clk        (clk),
    .rst        (rst),
    .start      (ptrStart),
    .base       (ptrBase),
    .count      (ptrNeed_r),
    .memRdValid (memRdValid),
    .memRdData  (memRdData),
    .memRdReq   (memRdReq),
    .memAddr    (memAddr),
    .ptrVal_r   (ptrVal),
    .done_r     (ptrDone)
  );

  ea_former u_ea (
    .mode   (mode_r),
    .idx    (useY_r ? yIndex : xIndex),
    .ext0   (ext0_r),
    .ext1   (ext1_r),
    .ptr    (ptrVal),
    .nextPc (nextPc),
    .ea     (eaNow),
    .target (targetNow)
  );

  // byte collection and sequencing; outputs refresh only on completion
  always @(posedge clk) begin
    if (rst) begin
      state_r          <= S_OPC;
      pre_r            <= `PRE_NONE;
      opc_r            <= 8'h00;
      mode_r           <= `MODE_INH;
      extNeed_r        <= 2'h0;
      extCnt_r         <= 2'h0;
      ptrNeed_r        <= 2'h0;
      useY_r           <= 1'b0;
      bad_r            <= 1'b0;
      ext0_r           <= 8'h00;
      ext1_r           <= 8'h00;
      len_r            <= 3'h0;
      pcBase_r         <= 16'h0000;
      decodeDone_r     <= 1'b0;
      modeOut_r        <= `MODE_INH;
      opcodeOut_r      <= 8'h00;
      instrLen_r       <= 3'h0;
      eaAddr_r         <= 16'h0000;
      immOperand_r     <= 8'h00;
      targetPc_r       <= 16'h0000;
      nextPc_r         <= 16'h0000;
      hasTarget_r      <= 1'b0;
      useSecondIndex_r <= 1'b0;
      illegalOp_r      <= 1'b0;
    end else begin
      decodeDone_r <= 1'b0;
      case (state_r)
        S_OPC: if (instrValid) begin
          len_r <= len_r + 3'h1;
          if (noPre)
            pcBase_r <= instrPc;
          if (isPre) begin
            pre_r <= preCode;
          end else begin
            opc_r     <= instrByte;
            mode_r    <= cMode;
            extNeed_r <= cExt;
            ptrNeed_r <= cPtr;
            useY_r    <= cY;
            bad_r     <= cBad;
            extCnt_r  <= 2'h0;
            // an illegal pair stops here, consuming no operand bytes
            if (cBad || cExt == 2'h0)
              state_r <= S_DONE;
            else
              state_r <= S_EXT;
          end
        end
        S_EXT: if (instrValid) begin
          len_r    <= len_r + 3'h1;
          extCnt_r <= extCnt_r + 2'h1;
          if (extCnt_r == 2'h0)
            ext0_r <= instrByte;
          else
            ext1_r <= instrByte;
          if (lastExt)
            state_r <= (ptrNeed_r != 2'h0) ? S_PTR : S_DONE;
        end
        S_PTR: if (ptrDone)
          state_r <= S_DONE; // pointer read before operand use
        S_DONE: begin
          decodeDone_r     <= 1'b1;
          modeOut_r        <= mode_r;
          opcodeOut_r      <= opc_r;
          instrLen_r       <= len_r;
          eaAddr_r         <= bad_r ? 16'h0000 : eaNow;
          immOperand_r     <= (mode_r == `MODE_IMM) ? ext0_r : 8'h00;
          targetPc_r       <= bad_r ? 16'h0000 : targetNow;
          nextPc_r         <= nextPc;
          hasTarget_r      <= !bad_r && (mode_r == `MODE_REL_D ||
                              mode_r == `MODE_REL_I ||
                              mode_r == `MODE_BITREL_D ||
                              mode_r == `MODE_BITREL_I);
          // an illegal pair reports no index choice, like its zero address
          useSecondIndex_r <= useY_r && !bad_r;
          illegalOp_r      <= bad_r;
          pre_r            <= `PRE_NONE;
          len_r            <= 3'h0;
          state_r          <= S_OPC;
        end
        default: state_r <= S_OPC;
      endcase
    end
  end
endmodule // addr_mode_decoder

/* File: sim/ptr_mem_model.sv */
// Purpose: page-zero pointer memory answering the decoder's byte reads
// Assumes: content is a fixed function of the address
// Notes:   lat sets idle cycles before each answer, bench changes it
`timescale 1ns/100ps
module ptr_mem_model (
  input  wire        clk,
  input  wire        rst,
  input  wire [1:0]  lat,
  input  wire        memRdReq,
  input  wire [15:0] memAddr,
  output wire        memRdValid,
  output wire [7:0]  memRdData
);
  reg [1:0] wait_r;
  reg [7:0] junk_r;

  // answer once lat cycles passed, wait restarts after every byte
  assign memRdValid = memRdReq && (wait_r == lat);
  // off-answer data churns so a stale byte is never mistaken for good
  assign memRdData  = memRdValid ? (memAddr[7:0] ^ 8'ha5)
                                 : junk_r;

  // wait counter and churn pattern
  always @(posedge clk) begin
    junk_r <= rst ? 8'h3c : ~junk_r;
    if (rst || !memRdReq || memRdValid)
      wait_r <= 2'h0;
    else
      wait_r <= wait_r + 2'h1;
  end
endmodule // ptr_mem_model

/* File: sim/addr_mode_decoder_monitor.sv */
// Purpose: port-level checks of the addressing-mode decoder
// Assumes: index inputs stay steady while a decode finishes
// Notes:   bound into every decoder instance
`timescale 1ns/100ps
`include "addr_decode_map.vh"
module addr_mode_decoder_monitor (
  input wire        clk,
  input wire        rst,
  input wire        instrReady,
  input wire [7:0]  xIndex,
  input wire [7:0]  yIndex,
  input wire        memRdReq,
  input wire [15:0] memAddr,
  input wire        memRdValid,
  input wire        decodeDone_r,
  input wire [4:0]  modeOut_r,
  input wire [2:0]  instrLen_r,
  input wire [15:0] eaAddr_r,
  input wire [15:0] targetPc_r,
  input wire [15:0] nextPc_r,
  input wire        hasTarget_r,
  input wire        useSecondIndex_r,
  input wire        illegalOp_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire [15:0] relDelta = targetPc_r - nextPc_r;
  wire        fin      = decodeDone_r;

  a_done_single: assert property (fin |=> !fin)
    else $error("done pulse longer than one cycle");
  a_len_bounds: assert property (
    fin |-> instrLen_r >= 3'h1 && instrLen_r <= 3'h4)
    else $error("length out of range");
  a_inh_length: assert property (
    fin && modeOut_r == `MODE_INH |->
    instrLen_r == (useSecondIndex_r ? 3'h2 : 3'h1))
    else $error("inherent length wrong");
  a_direct_page: assert property (
    fin && modeOut_r == `MODE_DIR_S |-> eaAddr_r[15:8] == 8'h00)
    else $error("short direct off page");
  a_noofs_index: assert property (
    fin && modeOut_r == `MODE_IDX_0 |->
    eaAddr_r == {8'h00, useSecondIndex_r ? yIndex : xIndex})
    else $error("no-offset address wrong");
  a_short_reach: assert property (
    fin && (modeOut_r == `MODE_IDX_S || modeOut_r == `MODE_INDX_S) |->
    eaAddr_r <= 16'h01fe) else $error("short indexed reach exceeded");
  a_rel_reach: assert property (
    fin && hasTarget_r |-> relDelta <= 16'h007f || relDelta >= 16'hff80)
    else $error("relative reach");
  a_illegal_clean: assert property (
    fin && illegalOp_r |-> !hasTarget_r && !useSecondIndex_r &&
    modeOut_r == `MODE_ILLEGAL && eaAddr_r == 16'h0000 &&
    targetPc_r == 16'h0000)
    else $error("illegal pair not clean");
  a_ptr_block: assert property (memRdReq |-> !instrReady)
    else $error("stream taken during pointer read");
  a_ptr_hold: assert property (
    memRdReq && !memRdValid |=> memRdReq && $stable(memAddr))
    else $error("pointer request dropped");
  a_ptr_step: assert property (
    memRdReq && memRdValid ##1 memRdReq |->
    memAddr == $past(memAddr) + 16'h0001)
    else $error("word pointer not sequential");
  a_ptr_finish: assert property (
    memRdReq ##1 !memRdReq |-> ##[1:3] fin)
    else $error("no done after pointer read");

  c_illegal: cover property (fin && illegalOp_r);
  c_word_ptr: cover property (memRdValid && memRdReq ##[1:3] memRdValid);
  c_relative: cover property (fin && hasTarget_r);
endmodule // addr_mode_decoder_monitor

bind addr_mode_decoder addr_mode_decoder_monitor u_addr_mode_decoder_monitor (
  .clk(clk), .rst(rst), .instrReady(instrReady), .xIndex(xIndex),
  .yIndex(yIndex), .memRdReq(memRdReq), .memAddr(memAddr),
  .memRdValid(memRdValid), .decodeDone_r(decodeDone_r),
  .modeOut_r(modeOut_r), .instrLen_r(instrLen_r), .eaAddr_r(eaAddr_r),
  .targetPc_r(targetPc_r), .nextPc_r(nextPc_r), .hasTarget_r(hasTarget_r),
  .useSecondIndex_r(useSecondIndex_r), .illegalOp_r(illegalOp_r));

/* File: sim/cpu_addressing_mode_decoder_bench.sv */
// Purpose: self-checking bench for the addressing-mode decoder
// Assumes: inputs change on the falling clock edge only
// Notes:   expected addresses come from the memory content formula
`timescale 1ns/100ps
`include "addr_decode_map.vh"
module cpu_addressing_mode_decoder_bench;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [7:0]  instrByte = 8'h00;
  reg         instrValid = 1'b0;
  reg  [15:0] instrPc = 16'h4000;
  reg  [7:0]  xIndex = 8'hff;
  reg  [7:0]  yIndex = 8'h34;
  reg  [1:0]  lat = 2'h0;
  wire        instrReady, memRdReq, memRdValid, decodeDone_r, hasTarget_r;
  wire        useSecondIndex_r, illegalOp_r;
  wire [15:0] memAddr, eaAddr_r, targetPc_r, nextPc_r;
  wire [7:0]  memRdData, opcodeOut_r, immOperand_r;
  wire [4:0]  modeOut_r;
  wire [2:0]  instrLen_r;
  integer     n_mismatch = 0;
  integer     checked = 0;
  integer     cyc = 0;

  always #25 clk = ~clk;

  addr_mode_decoder u_addr_mode_decoder (.clk(clk), .rst(rst),
    .instrByte(instrByte), .instrValid(instrValid), .instrPc(instrPc),
    .instrReady(instrReady), .xIndex(xIndex), .yIndex(yIndex),
    .memRdReq(memRdReq), .memAddr(memAddr), .memRdValid(memRdValid),
    .memRdData(memRdData), .decodeDone_r(decodeDone_r),
    .modeOut_r(modeOut_r), .opcodeOut_r(opcodeOut_r),
    .instrLen_r(instrLen_r), .eaAddr_r(eaAddr_r),
    .immOperand_r(immOperand_r), .targetPc_r(targetPc_r),
    .nextPc_r(nextPc_r), .hasTarget_r(hasTarget_r),
    .useSecondIndex_r(useSecondIndex_r), .illegalOp_r(illegalOp_r));
  ptr_mem_model u_ptr_mem_model (.clk(clk), .rst(rst), .lat(lat),
    .memRdReq(memRdReq), .memAddr(memAddr), .memRdValid(memRdValid),
    .memRdData(memRdData));

  function [7:0] mv(input [15:0] a);
    mv = a[7:0] ^ 8'ha5;
  endfunction
  function [15:0] sx(input [7:0] o);
    sx = {{8{o[7]}}, o};
  endfunction

  task chk(input string nm, input [15:0] seen, input [15:0] want);
    checked = checked + 1;
    if (seen !== want) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %s expected %h seen %h", nm, want, seen);
    end
  endtask

  // offer n bytes, left aligned in b, then wait for the done pulse
  task run(input [31:0] b, input [2:0] n);
    integer i;
    for (i = 0; i < n; i = i + 1) begin
      @(negedge clk);
      instrValid = 1'b1;
      instrByte  = b[31-8*i -: 8];
      while (instrReady !== 1'b1) @(negedge clk);
    end
    @(negedge clk);
    instrValid = 1'b0;
    while (decodeDone_r !== 1'b1) @(negedge clk);
  endtask

  // one decode compared against mode, length, address and target
  task dec(input [31:0] b, input [2:0] n, input [4:0] m, input [15:0] ea,
           input [7:0] rel, input sec, input ill);
    reg [15:0] t;
    reg [7:0]  op;
    t = (rel == 8'h00) ? 16'h0000 : instrPc + n + sx(rel);
    // the opcode sits behind a prebyte when one leads the stream
    op = (b[31:24] == `SECOND_INDEX_PREBYTE ||
          b[31:24] == `INDIRECT_PREBYTE ||
          b[31:24] == `SECOND_INDEX_INDIRECT_PREBYTE) ? b[23:16] : b[31:24];
    run(b, n);
    chk("opcode", opcodeOut_r, op);
    // a zero offset stands for no target in these scenarios
    chk("hastarget", hasTarget_r, rel != 8'h00);
    chk("mode", modeOut_r, m);
    chk("length", instrLen_r, n);
    chk("ea", eaAddr_r, ea);
    chk("nextpc", nextPc_r, instrPc + n);
    chk("target", targetPc_r, t);
    chk("second", useSecondIndex_r, sec);
    chk("illegal", illegalOp_r, ill);
  endtask

  task testPlain;
    dec(32'h9d000000, 1, `MODE_INH, 16'h0000, 8'h00, 0, 0);
    dec(32'ha6550000, 2, `MODE_IMM, 16'h0000, 8'h00, 0, 0);
    chk("imm", immOperand_r, 16'h0055);
    dec(32'hb6100000, 2, `MODE_DIR_S, 16'h0010, 8'h00, 0, 0);
    dec(32'hc6100000, 3, `MODE_DIR_L, 16'h1000, 8'h00, 0, 0);
    dec(32'h3c400000, 2, `MODE_DIR_S, 16'h0040, 8'h00, 0, 0);
    $display("test plain done");
  endtask

  task testIndexed;
    dec(32'hf6000000, 1, `MODE_IDX_0, 16'h00ff, 8'h00, 0, 0);
    dec(32'he6ff0000, 2, `MODE_IDX_S, 16'h01fe, 8'h00, 0, 0);
    dec(32'hd6123400, 3, `MODE_IDX_L, 16'h1333, 8'h00, 0, 0);
    dec(32'h90f60000, 2, `MODE_IDX_0, 16'h0034, 8'h00, 1, 0);
    dec(32'h90e6ff00, 3, `MODE_IDX_S, 16'h0133, 8'h00, 1, 0);
    $display("test indexed done");
  endtask

  task testIndirect;
    dec(32'h92b62000, 3, `MODE_IND_S, mv(16'h20), 8'h00, 0, 0);
    lat = 2'h2;
    dec(32'h92c62000, 3, `MODE_IND_L, {mv(16'h20), mv(16'h21)}, 8'h00,
        0, 0);
    dec(32'h92d6ff00, 3, `MODE_INDX_L, {mv(16'hff), mv(16'h100)} + 16'h00ff,
        8'h00, 0, 0);
    lat = 2'h0;
    dec(32'h92e62000, 3, `MODE_INDX_S, mv(16'h20) + 16'h00ff, 8'h00,
        0, 0);
    dec(32'h91e62000, 3, `MODE_INDX_S, mv(16'h20) + 16'h0034, 8'h00,
        1, 0);
    dec(32'h923c4000, 3, `MODE_IND_S, mv(16'h40), 8'h00, 0, 0);
    $display("test indirect done");
  endtask

  task testRelative;
    dec(32'h27800000, 2, `MODE_REL_D, 16'h0000, 8'h80, 0, 0);
    dec(32'h207f0000, 2, `MODE_REL_D, 16'h0000, 8'h7f, 0, 0);
    dec(32'had100000, 2, `MODE_REL_D, 16'h0000, 8'h10, 0, 0);
    dec(32'h92273000, 3, `MODE_REL_I, 16'h0000, mv(16'h30), 0, 0);
    dec(32'h00100500, 3, `MODE_BITREL_D, 16'h0010, 8'h05, 0, 0);
    dec(32'h92001005, 4, `MODE_BITREL_I, mv(16'h10), 8'h05, 0, 0);
    $display("test relative done");
  endtask

  task testIllegal;
    dec(32'hcc000000, 1, `MODE_ILLEGAL, 16'h0000, 8'h00, 0, 1);
    dec(32'h91b60000, 2, `MODE_ILLEGAL, 16'h0000, 8'h00, 0, 1);
    dec(32'h90920000, 2, `MODE_ILLEGAL, 16'h0000, 8'h00, 0, 1);
    dec(32'h92a60000, 2, `MODE_ILLEGAL, 16'h0000, 8'h00, 0, 1);
    $display("test illegal done");
  endtask

  task results;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard, all tests need well under a thousand cycles
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      n_mismatch = n_mismatch + 1;
      results;
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    chk("rstmode", modeOut_r, 16'h0000);
    chk("rstreq", memRdReq, 16'h0000);
    rst = 1'b0;
    @(negedge clk);
    chk("ready", instrReady, 16'h0001);
    testPlain;
    testIndexed;
    testIndirect;
    testRelative;
    testIllegal;
    results;
  end
endmodule // cpu_addressing_mode_decoder_bench
